// ---- src/lppc_pkg.sv ----
// package for the lvds pll and power control register bank
package lppc_pkg;
  localparam logic [7:0] LPPC_OFS_POWER_DOWN = 8'h76;
  localparam logic [7:0] LPPC_OFS_LOOP_CTRL = 8'h78;
  localparam logic [7:0] LPPC_OFS_SLIP_LIMIT = 8'h7f;
  localparam logic [7:0] LPPC_OFS_OUT_ENABLE = 8'h73;
  localparam logic [7:0] LPPC_OFS_AMPLITUDE = 8'h74;
  localparam logic [7:0] LPPC_OFS_SLIP_STATUS = 8'h80;
  localparam logic [7:0] LPPC_RST_POWER_DOWN = 8'had;
  localparam logic [7:0] LPPC_RST_LOOP_CTRL = 8'h38;
  localparam logic [7:0] LPPC_RST_SLIP_LIMIT = 8'h10;
  localparam logic [7:0] LPPC_RST_OUT_ENABLE = 8'hc8;
  localparam logic [7:0] LPPC_RST_AMPLITUDE = 8'hc0;
  localparam int LPPC_BIT_PATH_ON = 0;
  localparam int LPPC_BIT_PLL_RST_N = 2;
  localparam int LPPC_BIT_PLL_ON = 3;
  localparam int LPPC_LSB_LOOP_RES = 4;
  localparam int LPPC_BIT_FIFO_RST_N = 7;
  localparam int LPPC_LSB_PHASE_DET = 0;
  localparam int LPPC_LSB_LOOP_CAP = 5;
  localparam int LPPC_BIT_SPE_EN = 7;
  localparam int LPPC_BIT_DRV_EN = 3;
  localparam int LPPC_BIT_PULLDOWN = 7;
  localparam logic [31:0] LPPC_UNMAPPED_DATA = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] power_down;
    logic [7:0] loop_ctrl;
    logic [7:0] slip_limit;
    logic [7:0] out_enable;
    logic [7:0] amplitude;
  } lppc_regs_t;

  typedef struct packed {
    logic path_on;
    logic driver_enable;
    logic output_tristate;
    logic output_pulldown;
    logic pll_reset_n;
    logic pll_power_on;
    logic [2:0] loop_filter_sel;
    logic [1:0] loop_cap_sel;
    logic [4:0] phase_detector_cfg;
    logic static_phase_err_reduce_en;
    logic fifo_reset_n;
  } lppc_ctrl_t;
endpackage

// ---- src/lppc_slip_counter.sv ----
// per-frame fifo slip counter compared against a limit
`timescale 1ns/100ps
`default_nettype none
module lppc_slip_counter
  import lppc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic frame_start,
  input wire logic slip_event,
  input wire logic [7:0] limit,
  output logic [7:0] count,
  output logic exceeded
);
  typedef struct packed {
    logic [7:0] count;
    logic exceeded;
  } lppc_cnt_state_t;

  lppc_cnt_state_t state_reg;
  lppc_cnt_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (frame_start) begin
      // a slip in the first cycle of a frame still counts
      state_next.count = slip_event ? 8'h01 : 8'h00;
      state_next.exceeded = 1'b0;
    end else if (slip_event && state_reg.count != 8'hff) begin
      state_next.count = state_reg.count + 8'h01;
    end
    if (state_next.count > limit) begin
      state_next.exceeded = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign count = state_reg.count;
  assign exceeded = state_reg.exceeded;
endmodule // lppc_slip_counter
`default_nettype wire

// ---- src/lppc_regs.sv ----
// lvds pll, output power-down and fifo slip limit register bank on avalon-mm
//
// How it works
// - power-down register bit 0 low powers down the output data and clock path.
// - powered-down outputs tri-state, or pull to ground when pull-down enable is set.
// - pll reset bit low holds the pll in reset; high runs it.
// - pll power bit low powers the pll down; high keeps it running.
// - three loop filter resistor bits select one of eight resistances.
// - fifo reset bit low holds the pixel fifo in reset.
// - five low control bits configure the pll phase detector.
// - two control bits select the pll loop filter capacitance.
// - control register msb enables static phase error reduction.
// - limit register bounds fifo over and under-runs tolerated per frame.
// - driver enable bit low disables the output drivers, alongside power-down.
`timescale 1ns/100ps
`default_nettype none
module lppc_regs
  import lppc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire logic frame_start,
  input wire logic fifo_slip,
  output lppc_ctrl_t ctrl,
  output logic slip_limit_exceeded
);
  typedef struct packed {
    lppc_regs_t regs;
    logic ack;
    logic [31:0] rdata;
    logic [1:0] resp;
    lppc_ctrl_t ctrl;
  } lppc_state_t;

  lppc_state_t state_reg;
  lppc_state_t state_next;
  logic [7:0] slip_count;
  logic slip_exceeded;
  logic mapped;

  lppc_slip_counter u_slip_counter (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .frame_start(frame_start),
    .slip_event(fifo_slip),
    .limit(state_reg.regs.slip_limit),
    .count(slip_count),
    .exceeded(slip_exceeded)
  );

  always_comb begin
    case (avs_address)
      LPPC_OFS_POWER_DOWN, LPPC_OFS_LOOP_CTRL, LPPC_OFS_SLIP_LIMIT,
      LPPC_OFS_OUT_ENABLE, LPPC_OFS_AMPLITUDE, LPPC_OFS_SLIP_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    logic [7:0] pd;
    logic [7:0] lc;
    pd = 8'h00;
    lc = 8'h00;
    state_next = state_reg;
    state_next.ack = 1'b0;
    // one wait state: each access answers on the cycle after it is seen
    if ((avs_read || avs_write) && !state_reg.ack) begin
      state_next.ack = 1'b1;
      state_next.resp = mapped ? 2'b00 : 2'b10;
      state_next.rdata = LPPC_UNMAPPED_DATA;
      if (avs_read) begin
        case (avs_address)
          LPPC_OFS_POWER_DOWN: state_next.rdata = {24'h000000, state_reg.regs.power_down};
          LPPC_OFS_LOOP_CTRL: state_next.rdata = {24'h000000, state_reg.regs.loop_ctrl};
          LPPC_OFS_SLIP_LIMIT: state_next.rdata = {24'h000000, state_reg.regs.slip_limit};
          LPPC_OFS_OUT_ENABLE: state_next.rdata = {24'h000000, state_reg.regs.out_enable};
          LPPC_OFS_AMPLITUDE: state_next.rdata = {24'h000000, state_reg.regs.amplitude};
          LPPC_OFS_SLIP_STATUS: state_next.rdata = {23'h000000, slip_exceeded, slip_count};
          default: state_next.rdata = LPPC_UNMAPPED_DATA;
        endcase
      end
    end
    // a write lands only at the edge where the master sees waitrequest low
    if (avs_write && state_reg.ack && avs_byteenable[0]) begin
      case (avs_address)
        LPPC_OFS_POWER_DOWN: state_next.regs.power_down = avs_writedata[7:0];
        LPPC_OFS_LOOP_CTRL: state_next.regs.loop_ctrl = avs_writedata[7:0];
        LPPC_OFS_SLIP_LIMIT: state_next.regs.slip_limit = avs_writedata[7:0];
        LPPC_OFS_OUT_ENABLE: state_next.regs.out_enable = avs_writedata[7:0];
        LPPC_OFS_AMPLITUDE: state_next.regs.amplitude = avs_writedata[7:0];
        default: state_next.regs = state_reg.regs;
      endcase
    end
    // control outputs are decoded from the next fields, so they change at the same edge as a write
    pd = state_next.regs.power_down;
    lc = state_next.regs.loop_ctrl;
    state_next.ctrl.path_on = pd[LPPC_BIT_PATH_ON];
    state_next.ctrl.driver_enable = state_next.regs.out_enable[LPPC_BIT_DRV_EN]
      && pd[LPPC_BIT_PATH_ON];
    state_next.ctrl.output_pulldown = !pd[LPPC_BIT_PATH_ON]
      && state_next.regs.amplitude[LPPC_BIT_PULLDOWN];
    state_next.ctrl.output_tristate = !pd[LPPC_BIT_PATH_ON]
      && !state_next.regs.amplitude[LPPC_BIT_PULLDOWN];
    state_next.ctrl.pll_reset_n = pd[LPPC_BIT_PLL_RST_N];
    state_next.ctrl.pll_power_on = pd[LPPC_BIT_PLL_ON];
    state_next.ctrl.loop_filter_sel = pd[LPPC_LSB_LOOP_RES +: 3];
    state_next.ctrl.fifo_reset_n = pd[LPPC_BIT_FIFO_RST_N];
    state_next.ctrl.phase_detector_cfg = lc[LPPC_LSB_PHASE_DET +: 5];
    state_next.ctrl.loop_cap_sel = lc[LPPC_LSB_LOOP_CAP +: 2];
    state_next.ctrl.static_phase_err_reduce_en = lc[LPPC_BIT_SPE_EN];
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_reg.regs.power_down <= LPPC_RST_POWER_DOWN;
      state_reg.regs.loop_ctrl <= LPPC_RST_LOOP_CTRL;
      state_reg.regs.slip_limit <= LPPC_RST_SLIP_LIMIT;
      state_reg.regs.out_enable <= LPPC_RST_OUT_ENABLE;
      state_reg.regs.amplitude <= LPPC_RST_AMPLITUDE;
      state_reg.ack <= 1'b0;
      state_reg.rdata <= 32'h0000_0000;
      state_reg.resp <= 2'b00;
      // safe state in reset: pll and fifo held, path off and tri-stated
      state_reg.ctrl <= '0;
      state_reg.ctrl.output_tristate <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !state_reg.ack;
  assign avs_readdata = state_reg.rdata;
  assign avs_response = state_reg.resp;
  assign ctrl = state_reg.ctrl;
  assign slip_limit_exceeded = slip_exceeded;
endmodule // lppc_regs
`default_nettype wire

// ---- verification/lppc_regs_checker.sv ----
// concurrent checks on the register bank ports
`timescale 1ns/100ps
`default_nettype none
module lppc_regs_checker
  import lppc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic frame_start,
  input wire logic fifo_slip,
  input wire lppc_ctrl_t ctrl,
  input wire logic slip_limit_exceeded
);
  // write data is held through the ack cycle, so one stage lines it up with ctrl
  logic [31:0] wd_reg;
  always_ff @(posedge ref_clk) wd_reg <= avs_writedata;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence ack_s; avs_write && !avs_waitrequest && avs_byteenable[0]; endsequence
  sequence pd_s; ack_s ##0 avs_address == LPPC_OFS_POWER_DOWN; endsequence
  sequence lc_s; ack_s ##0 avs_address == LPPC_OFS_LOOP_CTRL; endsequence
  path_wr_a: assert property (pd_s |=> ctrl.path_on == wd_reg[0]) else $error("path bit");
  out_mode_a: assert property ((ctrl.output_tristate ^ ctrl.output_pulldown) == !ctrl.path_on
    && !(ctrl.output_tristate && ctrl.output_pulldown)) else $error("output mode");
  pwr_fields_a: assert property (pd_s |=> {ctrl.fifo_reset_n, ctrl.pll_power_on, ctrl.pll_reset_n}
    == {wd_reg[7], wd_reg[3:2]}) else $error("pll or fifo bit");
  lf_sel_a: assert property (pd_s |=> ctrl.loop_filter_sel == wd_reg[6:4]) else $error("resistor");
  loop_ctrl_a: assert property (lc_s |=> {ctrl.static_phase_err_reduce_en, ctrl.phase_detector_cfg}
    == {wd_reg[7], wd_reg[4:0]}) else $error("loop ctrl");
  cap_sel_a: assert property (lc_s |=> ctrl.loop_cap_sel == wd_reg[6:5]) else $error("capacitor");
  drv_gate_a: assert property (ctrl.driver_enable |-> ctrl.path_on) else $error("driver on");
  frame_clr_a: assert property (frame_start && !fifo_slip |=> !slip_limit_exceeded) else $error("frame");
endmodule // lppc_regs_checker
bind lppc_regs lppc_regs_checker i_lppc_regs_checker(.ref_clk, .reset_n, .avs_address, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_waitrequest, .frame_start, .fifo_slip, .ctrl, .slip_limit_exceeded);
`default_nettype wire

// ---- verification/lppc_host_model.sv ----
// host that programs the register bank over avalon-mm
`timescale 1ns/100ps
`default_nettype none
module lppc_host_model (
  input wire logic ref_clk,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic [1:0] avs_response,
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable
);
  initial {avs_address, avs_read, avs_write, avs_writedata, avs_byteenable} = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
    output logic [31:0] rd, output logic [1:0] rsp);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= d;
    avs_byteenable <= be;
    // waitrequest is taken as it stands just before each rising edge
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    rsp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
endmodule // lppc_host_model
`default_nettype wire

// ---- verification/test_lppc_regs.sv ----
// self-checking bench for the lvds pll and power register bank
`timescale 1ns/100ps
`default_nettype none
module test_lppc_regs
  import lppc_pkg::*;
;
  logic ref_clk = 1'b0, reset_n = 1'b0, frame_start = 1'b0, fifo_slip = 1'b0, avs_read, avs_write, avs_waitrequest;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable;
  logic [1:0] avs_response, rsp;
  lppc_ctrl_t ctrl;
  logic slip_limit_exceeded;
  integer n_errors = 0, checks_done = 0, seed = 32'hee025be2, lim, n;
  logic [7:0] mdl [logic [7:0]];
  logic [7:0] adr [6] = '{8'h73, 8'h74, 8'h76, 8'h78, 8'h7f, 8'h77};
  logic [15:0] rec [5] = '{16'h73db, 16'h74f6, 16'h76af, 16'h7880, 16'h7f10};
  always #10 ref_clk = ~ref_clk;
  lppc_regs i_lppc_regs(.ref_clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .avs_response, .frame_start, .fifo_slip, .ctrl, .slip_limit_exceeded);
  lppc_host_model i_lppc_host_model(.ref_clk, .avs_waitrequest, .avs_readdata, .avs_response, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
    i_lppc_host_model.xfer(1'b1, a, {24'h0, d}, be, rd, rsp);
    if (be[0] && mdl.exists(a)) mdl[a] = d;
  endtask
  task automatic rdchk(input logic [7:0] a);
    i_lppc_host_model.xfer(1'b0, a, 32'h0, 4'hf, rd, rsp);
    chk(rd, mdl.exists(a) ? {24'h0, mdl[a]} : 32'h0);
    chk(32'(rsp), mdl.exists(a) ? 32'h0 : 32'h2);
  endtask
  task automatic ctrl_chk();
    logic [7:0] a, b, c, e;
    a = mdl[8'h76];
    b = mdl[8'h78];
    c = mdl[8'h73];
    e = mdl[8'h74];
    @(negedge ref_clk);
    chk(32'(ctrl), 32'({a[0], a[0] & c[3], !a[0] & !e[7], !a[0] & e[7], a[2], a[3], a[6:4], b[6:5], b[4:0],
      b[7], a[7]}));
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    mdl[8'h73] = 8'hc8;
    mdl[8'h74] = 8'hc0;
    mdl[8'h76] = 8'had;
    mdl[8'h78] = 8'h38;
    mdl[8'h7f] = 8'h10;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    foreach (mdl[a]) rdchk(a);
    ctrl_chk();
    $display("reset values done");
    for (int i = 0; i < 40; i++) begin
      n = $random(seed);
      wr(adr[n[7:0] % 6], n[23:16], n[11:8]);
      ctrl_chk();
      rdchk(adr[n[31:24] % 6]);
    end
    $display("random access done");
    foreach (rec[i]) wr(rec[i][15:8], rec[i][7:0], 4'h1);
    ctrl_chk();
    $display("recommended values done");
    for (int k = 0; k < 6; k++) begin
      lim = $unsigned($random(seed)) % 6;
      n = $unsigned($random(seed)) % 10;
      wr(LPPC_OFS_SLIP_LIMIT, lim[7:0], 4'h1);
      @(posedge ref_clk) frame_start <= 1'b1;
      @(posedge ref_clk) frame_start <= 1'b0;
      repeat (n) begin
        @(posedge ref_clk) fifo_slip <= 1'b1;
        @(posedge ref_clk) fifo_slip <= 1'b0;
      end
      repeat (2) @(posedge ref_clk);
      chk(32'(slip_limit_exceeded), 32'(n > lim));
      i_lppc_host_model.xfer(1'b0, LPPC_OFS_SLIP_STATUS, 32'h0, 4'hf, rd, rsp);
      chk(rd, {23'h0, n > lim, n[7:0]});
    end
    $display("slip limit done");
    end_sim();
  end
  initial begin
    #200us;
    n_errors++;
    end_sim();
  end
endmodule // test_lppc_regs
`default_nettype wire
